// ===== rtl/iom_regs.vh
// constants for the i/o microsequencer: entry points, control word fields, timing, register map
`ifndef IOM_REGS_VH
`define IOM_REGS_VH
// entry points
`define IOM_ENT_SENSE 8'h04
`define IOM_ENT_DIN 8'h0C
`define IOM_ENT_DOUT 8'h1C
`define IOM_ENT_DMA_OUT 8'h40
`define IOM_ENT_DMA_IN 8'h50
`define IOM_ENT_HS_OUT 8'h70
`define IOM_ENT_HS_IN 8'h80
`define IOM_ENT_INTR 8'hDC
// control word bit positions
`define IOM_B_SRC_LO 0
`define IOM_B_SRC_HI 1
`define IOM_B_ACT_LO 2
`define IOM_B_ACT_HI 3
`define IOM_B_BUSY 7
`define IOM_B_DONE 3
`define IOM_B_EBUS 4
`define IOM_B_FRY 5
`define IOM_B_DRY 6
`define IOM_B_WAIT 8
`define IOM_B_RQM 9
`define IOM_B_CRY 10
`define IOM_B_EF0 11
`define IOM_B_EF2 13
`define IOM_STD_WORD 16'h0088
// event functions
`define IOM_EF_EXT 3'h0
`define IOM_EF_LOAD 3'h1
`define IOM_EF_ICNT 3'h2
`define IOM_EF_MEM 3'h3
`define IOM_EF_CPU 3'h4
`define IOM_EF_DRY 3'h5
`define IOM_EF_IACK 3'h6
// register byte offsets
`define IOM_REG_CTRL 8'h00
`define IOM_REG_STAT 8'h04
`define IOM_REG_WADDR 8'h08
`define IOM_REG_WDATA 8'h0C
`define IOM_REG_IOREG 8'h10
`define IOM_CTRL_RUN 0
`define IOM_CTRL_SOFTREQ 1
// strobe width in picoseconds and clock period
`define IOM_STROBE_PS 247500
`define IOM_CLK_PS 40000
`endif

// ===== rtl/iom_sync.v
// two-stage synchroniser for a bus of pin inputs
`timescale 1ns/100ps
`default_nettype none
module iom_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // iom_sync
`default_nettype wire

// ===== rtl/iom_strobe.v
// fixed-width strobe generator; restarts the count on each trigger
`timescale 1ns/100ps
`default_nettype none
`include "iom_regs.vh"
module iom_strobe #(
  parameter CYC = 6
) (
  input wire aclk,
  input wire aresetn,
  input wire trig,
  output reg strobe,
  output wire end_pulse
);
  reg [7:0] cnt_q;
  assign end_pulse = strobe && (cnt_q == 8'h01);
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      strobe <= 1'b0;
    end else if (trig) begin
      cnt_q <= CYC[7:0];
      strobe <= 1'b1;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      strobe <= (cnt_q != 8'h01);
    end
  end
endmodule // iom_strobe
`default_nettype wire

// ===== rtl/iom_seq.v
// i/o microsequencer top: control store, sequencer, i/o register, axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
`include "iom_regs.vh"
module iom_seq #(
  parameter AW = 8,
  parameter DEPTH = 256
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr_unused_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cpu_io_request,
  input wire [AW-1:0] cpu_start_addr,
  output wire cpu_req_accept,
  input wire [4:0] trap_req,
  input wire [15:0] alu_out,
  input wire [15:0] mem_data,
  input wire [15:0] io_bus_in,
  input wire ext_wait_line,
  input wire mem_cycle_done,
  input wire intr_flag_reset,
  output reg [15:0] io_reg,
  output reg [15:0] ebus_out,
  output reg ebus_out_en,
  output wire func_ready_strobe,
  output wire data_ready_strobe,
  output reg mem_cycle_req,
  output reg io_done_n,
  output reg seq_busy,
  output reg intr_counter_x,
  output reg intr_counter_f,
  output reg intr_ack
);
  localparam integer STROBE_CYC = (`IOM_STROBE_PS + `IOM_CLK_PS - 1) / `IOM_CLK_PS;
  // control store lives here; software fills it before enabling
  reg [15:0] cstore [0:DEPTH-1];
  reg [AW-1:0] addr_q;
  reg [15:0] cbuf_q;
  reg run_q;
  reg soft_req_q;
  reg [AW-1:0] soft_addr_q;
  reg [AW-1:0] waddr_q;
  wire [4:0] trap_s;
  wire ext_wait_s;
  wire mem_done_s;
  wire intr_rst_s;
  wire fry_end;
  wire dry_end;
  // pin-side inputs pass two flops
  iom_sync #(.W(8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({trap_req, ext_wait_line, mem_cycle_done, intr_flag_reset}),
    .q({trap_s, ext_wait_s, mem_done_s, intr_rst_s})
  );
  wire busy = cbuf_q[`IOM_B_BUSY];
  wire waitb = cbuf_q[`IOM_B_WAIT];
  wire [2:0] evt_fn = cbuf_q[`IOM_B_EF2:`IOM_B_EF0];
  wire [1:0] src_sel = {cbuf_q[`IOM_B_SRC_HI], cbuf_q[`IOM_B_SRC_LO]};
  wire [1:0] reg_act = {cbuf_q[`IOM_B_ACT_HI], cbuf_q[`IOM_B_ACT_LO]};
  // entry point for the highest-priority trap; interrupt ranks last
  function [AW-1:0] trap_entry;
    input [4:0] t;
    begin
      if (t[0]) begin
        trap_entry = `IOM_ENT_DMA_OUT;
      end else if (t[1]) begin
        trap_entry = `IOM_ENT_DMA_IN;
      end else if (t[2]) begin
        trap_entry = `IOM_ENT_HS_OUT;
      end else if (t[3]) begin
        trap_entry = `IOM_ENT_HS_IN;
      end else begin
        trap_entry = `IOM_ENT_INTR;
      end
    end
  endfunction
  wire cpu_start = cpu_io_request | soft_req_q;
  // bit 0 of a processor start address is forced to zero
  wire [AW-1:0] cpu_addr = soft_req_q ? soft_addr_q : {cpu_start_addr[AW-1:1], 1'b0};
  wire any_trap = |trap_s;
  // busy masks starts; requester stalls by holding its request
  wire start = run_q && !busy && (cpu_start || any_trap);
  assign cpu_req_accept = start && !any_trap && cpu_start;
  reg event_ok;
  always @* begin
    case (evt_fn)
      `IOM_EF_EXT: event_ok = ext_wait_s;
      `IOM_EF_MEM: event_ok = mem_done_s;
      `IOM_EF_CPU: event_ok = cpu_start;
      `IOM_EF_ICNT: event_ok = intr_rst_s;
      default: event_ok = 1'b1;
    endcase
  end
  wire hold = waitb && !event_ok;
  wire evt_load = busy && (evt_fn == `IOM_EF_LOAD) && cpu_start;
  always @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= {AW{1'b0}};
      cbuf_q <= 16'h0000;
    end else if (!run_q) begin
      addr_q <= addr_q;
    end else if (start || evt_load) begin
      addr_q <= any_trap && !evt_load ? trap_entry(trap_s) : cpu_addr;
      // standard word gives busy and done; a load event takes the word at the old address
      cbuf_q <= evt_load ? cstore[addr_q] : `IOM_STD_WORD;
    end else if (busy && !hold) begin
      cbuf_q <= cstore[addr_q];
      addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
    end
  end
  // i/o register input mux and actions
  reg [15:0] src_d;
  always @* begin
    case (src_sel)
      2'h2: src_d = {io_bus_in[7:0], io_bus_in[15:8]};
      2'h3: src_d = io_bus_in;
      2'h1: src_d = io_reg;
      default: src_d = mem_data;
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      io_reg <= 16'h0000;
    end else if (!busy) begin
      io_reg <= alu_out;
    end else begin
      case (reg_act)
        2'h1: io_reg <= {8'h00, io_reg[15:8]};
        2'h2: io_reg <= {io_reg[7:0], 8'h00};
        2'h3: io_reg <= src_sel[1] ? src_d : alu_out;
        default: io_reg <= io_reg;
      endcase
    end
  end
  wire fry_trig = busy && cbuf_q[`IOM_B_FRY] && !func_ready_strobe;
  wire dry_sel = cbuf_q[`IOM_B_DRY] || (waitb == 1'b0 && evt_fn == `IOM_EF_DRY);
  wire dry_trig = busy && dry_sel && !data_ready_strobe;
  iom_strobe #(.CYC(STROBE_CYC)) u_fry (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig(fry_trig),
    .strobe(func_ready_strobe),
    .end_pulse(fry_end)
  );
  iom_strobe #(.CYC(STROBE_CYC)) u_dry (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig(dry_trig),
    .strobe(data_ready_strobe),
    .end_pulse(dry_end)
  );
  always @(posedge aclk) begin
    if (!aresetn) begin
      ebus_out <= 16'h0000;
      ebus_out_en <= 1'b0;
      mem_cycle_req <= 1'b0;
      io_done_n <= 1'b1;
      seq_busy <= 1'b0;
      intr_counter_x <= 1'b0;
      intr_counter_f <= 1'b0;
      intr_ack <= 1'b0;
    end else begin
      ebus_out <= io_reg;
      ebus_out_en <= busy && cbuf_q[`IOM_B_EBUS];
      mem_cycle_req <= busy && cbuf_q[`IOM_B_RQM] && !hold;
      // done drops before busy clears one word later
      io_done_n <= !(busy && cbuf_q[`IOM_B_DONE]);
      seq_busy <= busy;
      intr_counter_x <= busy && evt_fn == `IOM_EF_ICNT && !waitb;
      intr_counter_f <= busy && evt_fn == `IOM_EF_ICNT && !waitb;
      intr_ack <= busy && evt_fn == `IOM_EF_IACK && !waitb;
    end
  end
  // axi4-lite slave
  reg aw_q;
  reg w_q;
  reg [7:0] awa_q;
  reg [31:0] wd_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire aw_have = aw_q || (s_axi_awvalid && s_axi_awready);
  wire w_have = w_q || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wa = aw_q ? awa_q : s_axi_awaddr;
  wire [31:0] wd = w_q ? wd_q : s_axi_wdata;
  wire wr_do = aw_have && w_have && !s_axi_bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      run_q <= 1'b0;
      soft_req_q <= 1'b0;
      soft_addr_q <= {AW{1'b0}};
      waddr_q <= {AW{1'b0}};
    end else begin
      if (soft_req_q && cpu_req_accept) begin
        soft_req_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_do) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (wa == `IOM_REG_CTRL) begin
          run_q <= wd[`IOM_CTRL_RUN];
          if (wd[`IOM_CTRL_SOFTREQ]) begin
            soft_req_q <= 1'b1;
            soft_addr_q <= wd[AW+7:8] & {{(AW-1){1'b1}}, 1'b0};
          end
        end else if (wa == `IOM_REG_WADDR) begin
          waddr_q <= wd[AW-1:0];
        end else if (wa == `IOM_REG_WDATA) begin
          waddr_q <= waddr_q + {{(AW-1){1'b0}}, 1'b1};
        end else begin
          s_axi_bresp <= 2'h2;
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_q <= 1'b1;
          awa_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_q <= 1'b1;
          wd_q <= s_axi_wdata;
        end
      end
    end
  end
  // store write port; only allowed while the sequencer is stopped
  always @(posedge aclk) begin
    if (wr_do && wa == `IOM_REG_WDATA && !run_q) begin
      cstore[waddr_q] <= wd[15:0];
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr == `IOM_REG_CTRL) begin
        s_axi_rdata <= {30'h0, soft_req_q, run_q};
      end else if (s_axi_araddr == `IOM_REG_STAT) begin
        s_axi_rdata <= {cbuf_q, {(16-AW){1'b0}}, addr_q};
      end else if (s_axi_araddr == `IOM_REG_WADDR) begin
        s_axi_rdata <= {{(32-AW){1'b0}}, waddr_q};
      end else if (s_axi_araddr == `IOM_REG_WDATA) begin
        s_axi_rdata <= {16'h0000, cstore[waddr_q]};
      end else if (s_axi_araddr == `IOM_REG_IOREG) begin
        s_axi_rdata <= {16'h0000, io_reg};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
    end
  end
endmodule // iom_seq
`default_nettype wire

// ===== testbench/iom_seq_assertions.sv
// port checker for the i/o microsequencer top
`timescale 1ns/100ps
`default_nettype none
module iom_seq_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cpu_io_request,
  input wire logic cpu_req_accept,
  input wire logic [15:0] alu_out,
  input wire logic [15:0] io_reg,
  input wire logic func_ready_strobe,
  input wire logic data_ready_strobe,
  input wire logic mem_cycle_req,
  input wire logic io_done_n,
  input wire logic seq_busy
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_done_low;
    !io_done_n;
  endsequence
  sequence s_strobe_run(sig);
    sig[*7] ##1 !sig;
  endsequence
  // seq_busy lags the buffer busy bit, so a held request may be taken while it is still high
  chk_accept_idle: assert property (cpu_req_accept |=> !cpu_req_accept)
    else $error("start taken while busy");
  chk_start_done: assert property (cpu_req_accept |-> ##2 s_done_low)
    else $error("standard word did not drive done");
  chk_start_busy: assert property (cpu_req_accept |-> ##[1:2] seq_busy)
    else $error("busy missing after start");
  chk_fry_width: assert property ($rose(func_ready_strobe) |-> s_strobe_run(func_ready_strobe))
    else $error("function strobe width");
  chk_dry_width: assert property ($rose(data_ready_strobe) |-> s_strobe_run(data_ready_strobe))
    else $error("data strobe width");
  chk_reset_idle: assert property ($rose(aresetn) |-> io_done_n && !seq_busy)
    else $error("not idle after reset");
  chk_done_first: assert property ($fell(seq_busy) |-> $past(io_done_n) == 1'b0)
    else $error("busy ended before done");
  chk_rqm_single: assert property ($rose(mem_cycle_req) |=> !mem_cycle_req)
    else $error("memory request too long");
  chk_idle_load: assert property ((!seq_busy && $stable(alu_out))[*4] |-> io_reg == alu_out)
    else $error("idle register not loaded");
endmodule // iom_seq_assertions
bind iom_seq iom_seq_assertions u_chk (.aclk(aclk), .aresetn(aresetn), .cpu_io_request(cpu_io_request),
  .cpu_req_accept(cpu_req_accept), .alu_out(alu_out), .io_reg(io_reg), .func_ready_strobe(func_ready_strobe),
  .data_ready_strobe(data_ready_strobe), .mem_cycle_req(mem_cycle_req), .io_done_n(io_done_n),
  .seq_busy(seq_busy));
`default_nettype wire

// ===== testbench/iom_cpu_model.sv
// processor-side model: holds start requests, echoes memory cycles
`timescale 1ns/100ps
`default_nettype none
module iom_cpu_model #(
  parameter AW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [AW-1:0] go_addr,
  input wire logic cpu_req_accept,
  input wire logic mem_cycle_req,
  output logic cpu_io_request,
  output logic [AW-1:0] cpu_start_addr,
  output logic mem_cycle_done
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_io_request <= 1'b0;
      cpu_start_addr <= '0;
      mem_cycle_done <= 1'b0;
    end else begin
      mem_cycle_done <= mem_cycle_req;
      if (go) begin
        cpu_io_request <= 1'b1;
        cpu_start_addr <= {go_addr[AW-1:1], 1'b0};
      end else if (cpu_req_accept) begin
        // held until taken; afterwards the address is junk on purpose
        cpu_io_request <= 1'b0;
        cpu_start_addr <= ~cpu_start_addr;
      end
    end
  end
endmodule // iom_cpu_model
`default_nettype wire

// ===== testbench/io_microsequencer_bench.sv
// self-checking bench for the i/o microsequencer
`timescale 1ns/100ps
`default_nettype none
`include "iom_regs.vh"
module io_microsequencer_bench;
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, ext_wait_line = 1'b0, intr_flag_reset = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, go_addr = 8'h00, cpu_start_addr;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr_unused_n = 4'h0, s_axi_wstrb = 4'hF;
  logic [15:0] alu_out = 16'h5AC3, mem_data = 16'h0, io_bus_in = 16'h0, io_reg, ebus_out;
  logic [4:0] trap_req = 5'h00;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_io_request;
  logic cpu_req_accept, mem_cycle_done, func_ready_strobe, data_ready_strobe, mem_cycle_req;
  logic io_done_n, seq_busy, intr_counter_x, intr_counter_f, intr_ack, ebus_out_en;
  logic seen_fry = 0, seen_dry = 0, seen_rqm = 0;
  int n_mismatch = 0, samples_checked = 0, i;
  logic [7:0] ent [7] = '{`IOM_ENT_SENSE, `IOM_ENT_DOUT, `IOM_ENT_DMA_OUT, `IOM_ENT_DMA_IN,
    `IOM_ENT_HS_OUT, `IOM_ENT_HS_IN, `IOM_ENT_INTR};
  logic [15:0] prog [8] = '{16'h0080, 16'h00A0, 16'h0280, 16'h28C0, 16'h0180, 16'h0088, 16'h0000, 16'h0088};
  iom_seq i_iom_seq (.aclk, .aresetn, .s_axi_awaddr_unused_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cpu_io_request, .cpu_start_addr, .cpu_req_accept, .trap_req, .alu_out, .mem_data, .io_bus_in,
    .ext_wait_line, .mem_cycle_done, .intr_flag_reset, .io_reg, .ebus_out, .ebus_out_en, .func_ready_strobe,
    .data_ready_strobe, .mem_cycle_req, .io_done_n, .seq_busy, .intr_counter_x, .intr_counter_f, .intr_ack);
  iom_cpu_model i_iom_cpu_model (.aclk, .aresetn, .go, .go_addr, .cpu_req_accept, .mem_cycle_req,
    .cpu_io_request, .cpu_start_addr, .mem_cycle_done);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    if (func_ready_strobe === 1'b1) seen_fry <= 1'b1;
    if (data_ready_strobe === 1'b1) seen_dry <= 1'b1;
    if (mem_cycle_req === 1'b1) seen_rqm <= 1'b1;
  end
  task automatic test_done;
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo;
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    test_done;
  endtask
  // master keeps each channel up until its own ready, then the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    @(posedge aclk);
    if (n >= 50) tmo;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge aclk);
    if (n >= 50) tmo;
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (seq_busy !== v && n < 100) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 100) tmo;
  endtask
  // t below zero starts from the processor, otherwise from that trap line
  task automatic start(input logic [7:0] a, input int t);
    if (t < 0) go <= 1'b1;
    else trap_req[t] <= 1'b1;
    go_addr <= a;
    @(posedge aclk);
    go <= 1'b0;
    wait_busy(1'b1);
    trap_req <= 5'h00;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(io_done_n, 1'b1);
    chk(seq_busy, 1'b0);
    rd(`IOM_REG_STAT);
    chk(rv, 32'h0);
    chk(io_reg, 16'h5AC3);
    alu_out <= 16'h3C5A;
    repeat (4) @(posedge aclk);
    chk(io_reg, 16'h3C5A);
    wr(8'h40, 32'h1);
    chk(rs, 2'h2);
    rd(8'h44);
    chk(rs, 2'h2);
    wr(`IOM_REG_WADDR, 32'h0);
    wr(`IOM_REG_WDATA, `IOM_STD_WORD);
    for (i = 0; i < 7; i++) begin
      wr(`IOM_REG_WADDR, {24'h0, ent[i]});
      wr(`IOM_REG_WDATA, 32'h0180);
      wr(`IOM_REG_WDATA, `IOM_STD_WORD);
      wr(`IOM_REG_WDATA, 32'h0);
      wr(`IOM_REG_WDATA, `IOM_STD_WORD);
    end
    wr(`IOM_REG_WADDR, 32'h0C);
    for (i = 0; i < 8; i++) wr(`IOM_REG_WDATA, {16'h0, prog[i]});
    wr(`IOM_REG_CTRL, 32'h1);
    // a store write while running must not land
    wr(`IOM_REG_WADDR, 32'h0D);
    wr(`IOM_REG_WDATA, 32'hFFFF);
    wr(`IOM_REG_WADDR, 32'h0D);
    rd(`IOM_REG_WDATA);
    chk(rv, 32'h00A0);
    for (i = 0; i < 7; i++) begin
      start(ent[i], i - 2);
      rd(`IOM_REG_STAT);
      chk(rv, {16'h0180, 8'h00, ent[i] + 8'h01});
      ext_wait_line <= 1'b1;
      wait_busy(1'b0);
      chk(io_done_n, 1'b1);
      ext_wait_line <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    start(`IOM_ENT_DIN, -1);
    repeat (10) @(posedge aclk);
    rd(`IOM_REG_STAT);
    chk(rv, 32'h01800011);
    chk(seen_fry, 1'b1);
    chk(seen_dry, 1'b1);
    chk(seen_rqm, 1'b1);
    go_addr <= `IOM_ENT_SENSE;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(cpu_io_request, 1'b1);
    ext_wait_line <= 1'b1;
    repeat (3) @(posedge aclk);
    ext_wait_line <= 1'b0;
    wait_busy(1'b0);
    wait_busy(1'b1);
    rd(`IOM_REG_STAT);
    chk(rv, 32'h01800005);
    ext_wait_line <= 1'b1;
    wait_busy(1'b0);
    chk(io_done_n, 1'b1);
    ext_wait_line <= 1'b0;
    test_done;
  end
endmodule // io_microsequencer_bench
`default_nettype wire
